// ===== design/tcu_pkg.sv
// Purpose: Shared constants and types for the 16-bit timer/counter block
// Assumes: 32-bit Avalon-MM slave, byte addresses, one register per word
// Notes:   Register fields sit in the low byte; upper bits read as zero
`default_nettype none
package tcu_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_LOW  = 5'h04;
  localparam logic [4:0] OFS_HIGH = 5'h08;
  localparam logic [4:0] OFS_STAT = 5'h0C;
  localparam logic [4:0] OFS_MASK = 5'h10;
  localparam logic [4:0] OFS_PINS = 5'h14;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [15:0] COUNT_TOP  = 16'hFFFF;
  localparam logic [7:0]  BUF_RST    = 8'h00;
  localparam logic [2:0]  PRE_RST    = 3'h0;
  localparam int          INSTR_DIV  = 4;     // Instruction cycle = Fosc/4
  localparam logic [1:0]  INSTR_LAST = 2'(INSTR_DIV - 1);
  localparam int          OVF_BIT    = 0;     // Overflow bit in status/mask
  localparam int          CTRL_RUN   = 6;     // Read-only clock status bit

  // ----------------------------------------------------------------
  // Control register layout, bit 7 down to bit 0
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wide_access_enable;
    logic       sysclk_from_secondary_osc;
    logic [1:0] input_prescale_select;
    logic       secondary_osc_enable;
    logic       ext_clock_sync_bypass;
    logic       clock_source_select;
    logic       counter_on;
  } tcu_ctrl_t;

  // Bus request as seen by the register file
  typedef struct packed {
    logic [4:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
    logic       lane0;
  } tcu_req_t;

endpackage
`default_nettype wire

// ===== design/tcu_sync_edge.sv
// Purpose: Two-stage synchroniser with rising-edge pulse for async inputs
// Assumes: Inputs are slow against clk_sys (at least two clocks per level)
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module tcu_sync_edge #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk_sys,   // System clock
  input  wire logic             reset_n,   // Async reset, active low
  input  wire logic [WIDTH-1:0] async_i,   // Levels from pins
  output logic      [WIDTH-1:0] level_o,   // Synchronised levels
  output logic      [WIDTH-1:0] rise_o     // One-cycle rising-edge pulses
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] last_q;

  // ----------------------------------------------------------------
  // Synchroniser and edge history
  // ----------------------------------------------------------------
  // Edge detector looks at the second stage only to avoid metastability
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o  = sync_q & ~last_q;

endmodule
`default_nettype wire

// ===== design/tcu_timer.sv
// Purpose: 16-bit up timer/counter with prescaler and buffered high byte
// Assumes: clk_sys is Fosc at 100 MHz; Avalon-MM slave with waitrequest
// Notes:   Oscillator analog part lives outside; only its enable leaves here
//
// Contract
// - Wide mode maps high address to buffer
// - Wide low read copies high into buffer
// - Wide low write loads high from buffer
// - Wide mode hides live high byte
// - Only low writes clear the prescaler
// - Prescale field divides 1, 2, 4, 8
// - Internal source counts each instruction cycle
// - External source counts pin or oscillator edges
// - Sync bit chooses synchroniser or bypass
// - Counter stops and holds when off
// - Oscillator enable bit switches oscillator
// - Status bit shows system clock source
// - Timer on forces pins input, read zero
// - Count wraps FFFFh to 0000h, sets flag
// - Interrupt only when overflow enable set
// - Compare trigger resets count, no flag
// - Software write beats trigger reset
`timescale 1ns/1ns
`default_nettype none
module tcu_timer (
  input  wire logic        clk_sys,          // System clock, Fosc
  input  wire logic        reset_n,          // Async reset, active low
  input  wire logic [4:0]  avs_address,      // Byte address
  input  wire logic        avs_read,         // Read request
  input  wire logic        avs_write,        // Write request
  input  wire logic [31:0] avs_writedata,    // Write data
  input  wire logic [3:0]  avs_byteenable,   // Byte lanes
  output logic      [31:0] avs_readdata,     // Read data, registered
  output logic             avs_waitrequest,  // Stall
  output logic             irq,              // Level interrupt
  input  wire logic        instr_clk_run,    // Instruction clock running
  input  wire logic        compare_trigger,  // Special event pulse
  input  wire logic        sysclk_is_secondary, // Async clock-source status
  input  wire logic        ext_count_clock_pin,   // Async pin level
  input  wire logic        secondary_osc_in_pin,  // Async oscillator output
  input  wire logic [1:0]  port_c_direction, // 1 = input, per pin
  output logic      [1:0]  pin_oe,           // Pin output enables
  output logic             secondary_osc_enable_o, // Oscillator on
  output logic      [15:0] count_o           // Live count
);

  tcu_pkg::tcu_ctrl_t ctrl_q;
  tcu_pkg::tcu_req_t  req;
  logic [15:0] count_q;
  logic [7:0]  buf_q;
  logic [2:0]  pre_q;
  logic [1:0]  div_q;
  logic        pend_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        stat_q;
  logic        mask_q;
  logic [2:0]  lvl;
  logic [2:0]  rise;
  logic        take;
  logic        acc;
  logic        wr_ctrl;
  logic        wr_low;
  logic        wr_high;
  logic        wr_stat;
  logic        wr_mask;
  logic        rd_low;
  logic        inst_tick;
  logic        ext_edge;
  logic        src_tick;
  logic        pre_done;
  logic        step;
  logic        wrap;
  logic [1:0]  pin_read;

  // Address decode used for both reads and writes
  function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
    hit = (a == o);
  endfunction

  // ----------------------------------------------------------------
  // Bus slave: one wait state, reads sample at the first edge, writes act at the completing edge
  // ----------------------------------------------------------------
  // One driver for the whole request word
  assign req = {avs_address, avs_read, avs_write, avs_writedata[7:0],
                avs_byteenable[0]};

  // First cycle of a request loads read data; second completes it
  assign take            = (req.rd | req.wr) & ~ack_q;
  assign acc             = (req.rd | req.wr) & ack_q;
  assign avs_waitrequest = (req.rd | req.wr) & ~ack_q;
  assign avs_readdata    = rdata_q;

  // Writes need lane 0 since every register is one byte wide
  assign wr_ctrl = acc & req.wr & req.lane0 & hit(req.addr, tcu_pkg::OFS_CTRL);
  assign wr_low  = acc & req.wr & req.lane0 & hit(req.addr, tcu_pkg::OFS_LOW);
  assign wr_high = acc & req.wr & req.lane0 & hit(req.addr, tcu_pkg::OFS_HIGH);
  assign wr_stat = acc & req.wr & req.lane0 & hit(req.addr, tcu_pkg::OFS_STAT);
  assign wr_mask = acc & req.wr & req.lane0 & hit(req.addr, tcu_pkg::OFS_MASK);
  assign rd_low  = take & req.rd & hit(req.addr, tcu_pkg::OFS_LOW);

  // Handshake state
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= take;
    end
  end

  // Read data snapshot; unmapped addresses read zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= '0;
    end else if (take & req.rd) begin
      unique case (req.addr)
        tcu_pkg::OFS_CTRL: rdata_q <= {24'h000000, ctrl_q};
        tcu_pkg::OFS_LOW:  rdata_q <= {24'h000000, count_q[7:0]};
        tcu_pkg::OFS_HIGH: begin
          // Buffer in wide mode, live byte otherwise
          rdata_q <= {24'h000000,
                      ctrl_q.wide_access_enable ? buf_q : count_q[15:8]};
        end
        tcu_pkg::OFS_STAT: rdata_q <= {31'h00000000, stat_q};
        tcu_pkg::OFS_MASK: rdata_q <= {31'h00000000, mask_q};
        tcu_pkg::OFS_PINS: rdata_q <= {30'h00000000, pin_read};
        default:           rdata_q <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control register and pin-side effects
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= tcu_pkg::CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= req.wdata;
      end
      // Status bit is never writable; it mirrors the clock mux
      ctrl_q.sysclk_from_secondary_osc <= lvl[2];
    end
  end

  // Oscillator drive follows its enable bit
  assign secondary_osc_enable_o = ctrl_q.secondary_osc_enable;

  // Running timer owns both pins: no drive, port reads zero
  assign pin_oe   = ctrl_q.counter_on ? 2'b00 : ~port_c_direction;
  assign pin_read = ctrl_q.counter_on ? 2'b00 : lvl[1:0];

  // Pins and the clock status arrive from other domains
  tcu_sync_edge #(
    .WIDTH   (3)
  ) u_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .async_i ({sysclk_is_secondary, secondary_osc_in_pin,
               ext_count_clock_pin}),
    .level_o (lvl),
    .rise_o  (rise)
  );

  // ----------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------
  // Fosc/4 divider, stalled while the instruction clock is stopped
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= '0;
    end else if (instr_clk_run) begin
      div_q <= (div_q == tcu_pkg::INSTR_LAST) ? 2'h0 : div_q + 2'h1;
    end
  end

  assign inst_tick = instr_clk_run & (div_q == tcu_pkg::INSTR_LAST);

  // Oscillator edge replaces the pin edge when enabled
  assign ext_edge = ctrl_q.secondary_osc_enable ? rise[1] : rise[0];

  // Synchronised mode holds an edge until the next instruction cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pend_q <= 1'b0;
    end else if (inst_tick) begin
      pend_q <= 1'b0;
    end else if (ext_edge & ctrl_q.clock_source_select &
                 ~ctrl_q.ext_clock_sync_bypass) begin
      // Only synchronised mode may hold an edge, so none goes stale
      pend_q <= 1'b1;
    end
  end

  // Bypass counts raw edges even with instruction clock off
  always_comb begin
    if (!ctrl_q.clock_source_select) begin
      src_tick = inst_tick;
    end else if (ctrl_q.ext_clock_sync_bypass) begin
      src_tick = ext_edge;
    end else begin
      src_tick = inst_tick & (pend_q | ext_edge);
    end
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Terminal value is 2^ps - 1: 0, 1, 3 or 7
  assign pre_done = (pre_q == 3'((4'h1 << ctrl_q.input_prescale_select)
                                 - 4'h1));

  // High-byte writes leave the prescaler alone
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= tcu_pkg::PRE_RST;
    end else if (wr_low) begin
      pre_q <= tcu_pkg::PRE_RST;
    end else if (ctrl_q.counter_on & src_tick) begin
      pre_q <= pre_done ? tcu_pkg::PRE_RST : pre_q + 3'h1;
    end
  end

  assign step = ctrl_q.counter_on & src_tick & pre_done;
  // A trigger or software load replaces the wrap, so no flag then
  assign wrap = step & (count_q == tcu_pkg::COUNT_TOP) & ~compare_trigger &
                ~wr_low & ~(wr_high & ~ctrl_q.wide_access_enable);

  // ----------------------------------------------------------------
  // Counter and high-byte buffer
  // ----------------------------------------------------------------
  // Write first, then trigger reset, then increment
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= tcu_pkg::COUNT_RST;
    end else if (wr_low | (wr_high & ~ctrl_q.wide_access_enable)) begin
      if (wr_low) begin
        count_q[7:0] <= req.wdata;
        // Wide mode moves the buffer in with the low byte
        if (ctrl_q.wide_access_enable) begin
          count_q[15:8] <= buf_q;
        end
      end else begin
        count_q[15:8] <= req.wdata;
      end
    end else if (compare_trigger) begin
      count_q <= tcu_pkg::COUNT_RST;
    end else if (step) begin
      count_q <= count_q + 16'h0001;
    end
  end

  assign count_o = count_q;

  // Buffer takes high writes in wide mode and snapshots on low reads
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      buf_q <= tcu_pkg::BUF_RST;
    end else if (ctrl_q.wide_access_enable) begin
      if (rd_low) begin
        buf_q <= count_q[15:8];
      end else if (wr_high) begin
        buf_q <= req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  // Set beats a same-cycle write-one clear, so no overflow is lost
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stat_q <= 1'b0;
    end else if (wrap) begin
      stat_q <= 1'b1;
    end else if (wr_stat & req.wdata[tcu_pkg::OVF_BIT]) begin
      stat_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mask_q <= 1'b0;
    end else if (wr_mask) begin
      mask_q <= req.wdata[tcu_pkg::OVF_BIT];
    end
  end

  assign irq = stat_q & mask_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_low_write;
    wr_low;
  endsequence

  sequence s_wide_low_read;
    rd_low ##0 ctrl_q.wide_access_enable;
  endsequence

  a_wide_read_copy: assert property (
    s_wide_low_read |=> buf_q == $past(count_q[15:8]))
    else $error("buffer missed high byte on low read");

  a_wide_write_load: assert property (
    s_low_write ##0 ctrl_q.wide_access_enable
      |=> count_q == {$past(buf_q), $past(req.wdata)})
    else $error("wide low write did not load 16 bits");

  a_high_via_buf: assert property (
    wr_high & ctrl_q.wide_access_enable & ~compare_trigger & ~step
      |=> count_q[15:8] == $past(count_q[15:8]) && buf_q == $past(req.wdata))
    else $error("wide high write reached live byte");

  a_pre_clear: assert property (
    s_low_write |=> pre_q == tcu_pkg::PRE_RST)
    else $error("low write did not clear prescaler");

  a_stop_hold: assert property (
    ~ctrl_q.counter_on & ~wr_low & ~wr_high & ~compare_trigger
      |=> count_q == $past(count_q))
    else $error("count moved while off");

  a_wrap_flag: assert property (
    wrap & ~wr_low & ~wr_high & ~compare_trigger
      |=> count_q == 16'h0000 && stat_q)
    else $error("wrap did not clear count and set flag");

  a_irq_gate: assert property (
    wrap & ~mask_q & ~wr_mask |=> stat_q && !irq)
    else $error("masked overflow lost flag or raised interrupt");

  a_trig_reset: assert property (
    compare_trigger & ~wr_low & ~wr_high & ~wr_stat
      |=> count_q == 16'h0000 && stat_q == $past(stat_q))
    else $error("trigger did not reset count or touched flag");

  a_write_wins: assert property (
    s_low_write ##0 compare_trigger |=> count_q[7:0] == $past(req.wdata))
    else $error("trigger beat software write");

  a_pin_input: assert property (
    ctrl_q.counter_on |-> pin_oe == 2'b00 && pin_read == 2'b00)
    else $error("pins driven while timer on");

endmodule
`default_nettype wire

// ===== verification/tcu_clk_src_model.sv
// Purpose: Far-side clock source, external count pin and oscillator
// Assumes: Eight system clocks per period, slow against clk_sys
// Notes:   Lines rest low between bursts; nothing runs free
`timescale 1ns/1ns
`default_nettype none
module tcu_clk_src_model (
  input  wire logic       clk_sys,  // Bench clock
  input  wire logic       go,       // Start a burst
  input  wire logic [7:0] n_edges,  // Rising edges per burst
  input  wire logic       osc_en,   // Oscillator enable from the timer
  output logic            ext_pin,  // External count clock
  output logic            osc_pin   // Oscillator output
);
  // ------------------------------------------------------------
  // Burst generator
  // ------------------------------------------------------------
  // A shut-off oscillator stays silent, so edges go to the pin
  initial begin
    ext_pin = 1'b0;
    osc_pin = 1'b0;
    forever begin
      @(posedge go);
      repeat (n_edges) begin
        repeat (4) @(posedge clk_sys);
        if (osc_en) osc_pin <= 1'b1;
        else ext_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        osc_pin <= 1'b0;
        ext_pin <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/sixteen_bit_timer_counter_tb_top.sv
// Purpose: Self-checking bench for the 16-bit timer/counter
// Assumes: One wait state per bus request, deltas over whole periods
// Notes:   Windows span whole count periods so phase cannot skew them
`timescale 1ns/1ns
`default_nettype none
module sixteen_bit_timer_counter_tb_top;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        instr_clk_run = 1'b1;
  logic        compare_trigger = 1'b0;
  logic        sysclk_is_secondary = 1'b0;
  logic        ext_pin;
  logic        osc_pin;
  logic        osc_en_o;
  logic [1:0]  port_c_direction = 2'h0;
  logic [1:0]  pin_oe;
  logic [15:0] count_o;
  logic        go = 1'b0;
  logic [7:0]  n_edges = 8'h00;
  logic [7:0]  rd;
  logic [7:0]  h;
  logic [7:0]  l;
  logic [15:0] c0;
  int          err_count = 0;
  int          cmp_count = 0;
  int          seed = 37;

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  tcu_timer DUT (.clk_sys(clk_sys), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .instr_clk_run(instr_clk_run),
    .compare_trigger(compare_trigger),
    .sysclk_is_secondary(sysclk_is_secondary),
    .ext_count_clock_pin(ext_pin), .secondary_osc_in_pin(osc_pin),
    .port_c_direction(port_c_direction), .pin_oe(pin_oe),
    .secondary_osc_enable_o(osc_en_o), .count_o(count_o));

  tcu_clk_src_model src (.clk_sys(clk_sys), .go(go), .n_edges(n_edges),
    .osc_en(osc_en_o), .ext_pin(ext_pin), .osc_pin(osc_pin));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holds the request until waitrequest is sampled low; trig pulses
  // the compare trigger into the completing cycle
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [7:0] d, input logic trig);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      if (n == 1 && trig) compare_trigger <= 1'b1;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk("waitrequest", avs_waitrequest, 16'h0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    compare_trigger <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask

  task automatic rdr(input logic [4:0] a);
    bus(1'b0, a, 8'h00, 1'b0);
  endtask

  function automatic int per(input int ps);
    return tcu_pkg::INSTR_DIV << ps;
  endfunction

  // Sends n partner edges and checks that the count moved by n
  task automatic burst(input logic [7:0] n, input string what);
    c0 = count_o;
    n_edges <= n;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (8 * n + 12) @(posedge clk_sys);
    chk(what, count_o - c0, {8'h00, n});
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    port_c_direction <= 2'($random(seed));
    rdr(tcu_pkg::OFS_CTRL);
    chk("ctrl rst", rd, tcu_pkg::CTRL_RST);
    chk("irq rst", irq, 16'h0);
    chk("pin_oe off", pin_oe, {14'h0000, ~port_c_direction});
    $display("test reset done");
    // Every prescale code, bypass bit toggled under internal source
    for (int ps = 0; ps < 4; ps++) begin
      wr(tcu_pkg::OFS_CTRL, {2'b00, 2'(ps), 1'b0, 1'(ps), 2'b01});
      wr(tcu_pkg::OFS_LOW, 8'h00);
      repeat (7) @(posedge clk_sys);
      c0 = count_o;
      repeat (8 * per(ps)) @(posedge clk_sys);
      chk("ps delta", count_o - c0, 16'h0008);
      chk("pin_oe on", pin_oe, 16'h0);
    end
    rdr(tcu_pkg::OFS_PINS);
    chk("pins", rd, 16'h0);
    wr(tcu_pkg::OFS_CTRL, 8'h30);
    c0 = count_o;
    repeat (40) @(posedge clk_sys);
    chk("hold", count_o, c0);
    $display("test prescale done");
    // Overflow from near the top, interrupt masked then enabled
    wr(tcu_pkg::OFS_CTRL, 8'h00);
    wr(tcu_pkg::OFS_HIGH, 8'hFF);
    wr(tcu_pkg::OFS_LOW, 8'hF0);
    @(posedge clk_sys);
    chk("narrow", count_o, 16'hFFF0);
    wr(tcu_pkg::OFS_CTRL, 8'h01);
    repeat (100) @(posedge clk_sys);
    chk("wrap", count_o < 16'h0020, 16'h1);
    rdr(tcu_pkg::OFS_STAT);
    chk("ovf", rd[tcu_pkg::OVF_BIT], 16'h1);
    chk("irq masked", irq, 16'h0);
    wr(tcu_pkg::OFS_MASK, 8'h01);
    @(posedge clk_sys);
    chk("irq on", irq, 16'h1);
    wr(tcu_pkg::OFS_STAT, 8'h01);
    @(posedge clk_sys);
    chk("irq clr", irq, 16'h0);
    // Trigger clears the count without flagging
    @(posedge clk_sys);
    compare_trigger <= 1'b1;
    @(posedge clk_sys);
    compare_trigger <= 1'b0;
    @(posedge clk_sys);
    chk("trig clr", count_o < 16'h0002, 16'h1);
    rdr(tcu_pkg::OFS_STAT);
    chk("trig flag", rd[tcu_pkg::OVF_BIT], 16'h0);
    wr(tcu_pkg::OFS_CTRL, 8'h00);
    bus(1'b1, tcu_pkg::OFS_LOW, 8'h5A, 1'b1);
    @(posedge clk_sys);
    chk("wr beats trig", count_o[7:0], 16'h005A);
    $display("test overflow done");
    // Wide mode through the buffer, counter stopped
    wr(tcu_pkg::OFS_CTRL, 8'h80);
    c0 = count_o;
    h = 8'($random(seed));
    l = 8'($random(seed));
    wr(tcu_pkg::OFS_HIGH, h);
    @(posedge clk_sys);
    chk("live high", count_o[15:8], c0[15:8]);
    wr(tcu_pkg::OFS_LOW, l);
    @(posedge clk_sys);
    chk("wide wr", count_o, {h, l});
    wr(tcu_pkg::OFS_HIGH, ~h);
    rdr(tcu_pkg::OFS_LOW);
    chk("wide lo", rd, l);
    rdr(tcu_pkg::OFS_HIGH);
    chk("wide hi", rd, h);
    avs_byteenable <= 4'h0;
    wr(tcu_pkg::OFS_LOW, ~l);
    avs_byteenable <= 4'hF;
    wr(5'h18, 8'hFF);
    rdr(5'h18);
    chk("unmapped", rd, 16'h0);
    chk("lane off", count_o, {h, l});
    $display("test wide done");
    // External pin unsynchronised with the instruction clock stopped, then synchronised, then oscillator
    wr(tcu_pkg::OFS_CTRL, 8'h07);
    instr_clk_run <= 1'b0;
    burst(8'h05, "async pin");
    instr_clk_run <= 1'b1;
    wr(tcu_pkg::OFS_CTRL, 8'h03);
    burst(8'h05, "sync pin");
    wr(tcu_pkg::OFS_CTRL, 8'h0F);
    @(posedge clk_sys);
    chk("osc on", osc_en_o, 16'h1);
    burst(8'h03, "osc");
    wr(tcu_pkg::OFS_CTRL, 8'h00);
    @(posedge clk_sys);
    chk("osc off", osc_en_o, 16'h0);
    $display("test external done");
    // Clock status bit follows the input and ignores writes
    sysclk_is_secondary <= 1'b1;
    repeat (6) @(posedge clk_sys);
    wr(tcu_pkg::OFS_CTRL, 8'h00);
    rdr(tcu_pkg::OFS_CTRL);
    chk("run set", rd[tcu_pkg::CTRL_RUN], 16'h1);
    sysclk_is_secondary <= 1'b0;
    repeat (6) @(posedge clk_sys);
    wr(tcu_pkg::OFS_CTRL, 8'h40);
    rdr(tcu_pkg::OFS_CTRL);
    chk("run clr", rd[tcu_pkg::CTRL_RUN], 16'h0);
    $display("test status done");
    summarize();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    summarize();
  end
endmodule
`default_nettype wire
